//--- hdl/bcb_map.vh
// Register offsets, field positions, reset values and timing counts
`ifndef BCB_MAP_VH
`define BCB_MAP_VH

`define BCB_PORT_SEL_ADDR 8'h4c
`define BCB_BIST_CNT_ADDR 8'h57
`define BCB_CFG_ADDR 8'h58

`define BCB_PSEL_WEN0 0
`define BCB_PSEL_WEN1 1
`define BCB_PSEL_RDP 4
`define BCB_PSEL_RST 8'h01

`define BCB_CFG_PASS_ALL 7
`define BCB_CFG_PASS_MATCH 6
`define BCB_CFG_AUTO_ACK 5
`define BCB_CFG_FORCE_ON 4
`define BCB_CFG_CHECK_GEN 3
`define BCB_CFG_RATE_HI 2
`define BCB_CFG_RATE_LO 0
`define BCB_CFG_RST_UPPER 5'h03
`define BCB_RATE_RST 3'h6

`define BCB_RATE_2M5 3'h0
`define BCB_RATE_10M 3'h2
`define BCB_RATE_25M 3'h5
`define BCB_RATE_50M 3'h6
`define BCB_RATE_100M 3'h7

`define BCB_CLK_PERIOD_NS 20
`define BCB_BIT_NS_2M5 400
`define BCB_BIT_NS_10M 100
`define BCB_BIT_NS_25M 40
`define BCB_BIT_NS_50M 20
`define BCB_BIT_NS_100M 10
`define BCB_CYC_2M5 5'h14
`define BCB_CYC_10M 5'h05
`define BCB_CYC_25M 5'h02
`define BCB_CYC_50M 5'h01
`define BCB_CYC_100M 5'h01

`endif

//--- hdl/bcb_rate_gen.v
// Return link bit-rate enable divider for one receive port
`timescale 1ns/1ps
`include "bcb_map.vh"
module bcb_rate_gen (
  input wire clk_i,
  input wire resetn_i,
  input wire [2:0] rate_sel_i,
  output wire tick_o
);
  localparam [4:0] CYC_2M5 = `BCB_CYC_2M5;
  localparam [4:0] CYC_10M = `BCB_CYC_10M;
  localparam [4:0] CYC_25M = `BCB_CYC_25M;
  localparam [4:0] CYC_50M = `BCB_CYC_50M;
  localparam [4:0] CYC_100M = `BCB_CYC_100M;

  reg [4:0] cnt_ff;
  reg [4:0] nxt_cnt;
  reg [2:0] rate_ff;
  reg tick_ff;
  reg nxt_tick;
  reg [4:0] period;
  reg valid_rate;

  // Period per rate code; reserved codes produce no ticks
  always @* begin
    period = CYC_50M;
    valid_rate = 1'b1;
    case (rate_sel_i)
      `BCB_RATE_2M5: period = CYC_2M5;
      `BCB_RATE_10M: period = CYC_10M;
      `BCB_RATE_25M: period = CYC_25M;
      `BCB_RATE_50M: period = CYC_50M;
      `BCB_RATE_100M: period = CYC_100M;
      default: valid_rate = 1'b0;
    endcase
  end

  // Restart on rate change; the odd bit around it may be lost
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (rate_sel_i != rate_ff || !valid_rate) begin
      nxt_cnt = 5'h00;
    end else if (cnt_ff >= period - 5'h01) begin
      nxt_cnt = 5'h00;
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 5'h01;
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_ff <= 5'h00;
      rate_ff <= `BCB_RATE_RST;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      rate_ff <= rate_sel_i;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule

//--- hdl/bcb_config_bank.v
// Per-port return channel configuration and self-test count bank
`timescale 1ns/1ps
`include "bcb_map.vh"
module bcb_config_bank (
  input wire clk_i,
  input wire resetn_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire reg_remote_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input wire [2:0] strap_rate_i,
  input wire powerdown_release_pin_i,
  input wire [1:0] txn_valid_i,
  input wire [1:0] txn_match_i,
  input wire txn_write_i,
  input wire [1:0] remote_ack_i,
  input wire [1:0] bist_err_i,
  output wire [1:0] fwd_o,
  output wire [1:0] ack_o,
  output wire [1:0] return_link_en_o,
  output wire [1:0] return_link_check_gen_en_o,
  output wire [5:0] return_link_rate_sel_o,
  output wire [1:0] return_link_tick_o
);
  reg [7:0] psel_ff;
  reg [7:0] cfg_ff [0:1];
  reg [7:0] bist_cnt_ff [0:1];
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg [1:0] fwd_ff;
  reg [1:0] ack_ff;
  reg [1:0] en_ff;
  reg [1:0] crc_ff;
  reg [5:0] rate_ff;
  reg [2:0] rel_sync_ff;
  reg [2:0] strap_s1_ff;
  reg [2:0] strap_s2_ff;
  reg [2:0] strap_s3_ff;
  reg rel_state_ff;
  reg [2:0] strap_state_ff;
  wire rel_rise;
  wire [1:0] tick;
  wire rd_port;
  wire [1:0] pass_all;
  wire [1:0] pass_match;
  wire [1:0] auto_ack;
  wire [1:0] force_on;
  wire [1:0] check_gen;
  integer i;

  assign rd_port = psel_ff[`BCB_PSEL_RDP];

  // Decoded control fields of each port copy
  assign pass_all = {cfg_ff[1][`BCB_CFG_PASS_ALL],
    cfg_ff[0][`BCB_CFG_PASS_ALL]};
  assign pass_match = {cfg_ff[1][`BCB_CFG_PASS_MATCH],
    cfg_ff[0][`BCB_CFG_PASS_MATCH]};
  assign auto_ack = {cfg_ff[1][`BCB_CFG_AUTO_ACK],
    cfg_ff[0][`BCB_CFG_AUTO_ACK]};
  assign force_on = {cfg_ff[1][`BCB_CFG_FORCE_ON],
    cfg_ff[0][`BCB_CFG_FORCE_ON]};
  assign check_gen = {cfg_ff[1][`BCB_CFG_CHECK_GEN],
    cfg_ff[0][`BCB_CFG_CHECK_GEN]};

  // Pin synchronisers: a change counts once stages two and three agree
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rel_sync_ff <= 3'h0;
      strap_s1_ff <= 3'h0;
      strap_s2_ff <= 3'h0;
      strap_s3_ff <= 3'h0;
      rel_state_ff <= 1'b0;
      strap_state_ff <= 3'h0;
    end else begin
      rel_sync_ff <= {rel_sync_ff[1:0], powerdown_release_pin_i};
      strap_s1_ff <= strap_rate_i;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (rel_sync_ff[1] == rel_sync_ff[2]) begin
        rel_state_ff <= rel_sync_ff[2];
      end
      if (strap_s2_ff == strap_s3_ff) begin
        strap_state_ff <= strap_s3_ff;
      end
    end
  end

  assign rel_rise = rel_sync_ff[1] && rel_sync_ff[2] && !rel_state_ff;

  // Port select register
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      psel_ff <= `BCB_PSEL_RST;
    end else if (reg_wr_i && reg_addr_i == `BCB_PORT_SEL_ADDR) begin
      psel_ff <= reg_wdata_i & 8'h13;
    end
  end

  // Configuration copies, one per port
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        cfg_ff[i] <= {`BCB_CFG_RST_UPPER, `BCB_RATE_RST};
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (rel_rise) begin
          cfg_ff[i][`BCB_CFG_RATE_HI:`BCB_CFG_RATE_LO] <=
            strap_state_ff;
        end
        if (reg_wr_i && reg_addr_i == `BCB_CFG_ADDR && psel_ff[i]) begin
          cfg_ff[i][7:5] <= reg_wdata_i[7:5];
          cfg_ff[i][3:0] <= reg_wdata_i[3:0];
          if (!reg_remote_i) begin
            cfg_ff[i][`BCB_CFG_FORCE_ON] <=
              reg_wdata_i[`BCB_CFG_FORCE_ON];
          end
        end
      end
    end
  end

  // Self-test error counters, saturating, read only
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        bist_cnt_ff[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (bist_err_i[i] && bist_cnt_ff[i] != 8'hff) begin
          bist_cnt_ff[i] <= bist_cnt_ff[i] + 8'h01;
        end
      end
    end
  end

  // Read data from the copy chosen by the read port select
  always @* begin
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `BCB_PORT_SEL_ADDR: nxt_rdata = psel_ff;
        `BCB_BIST_CNT_ADDR: nxt_rdata = bist_cnt_ff[rd_port];
        `BCB_CFG_ADDR: nxt_rdata = cfg_ff[rd_port];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Per-port forwarding, acknowledge and return channel controls
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      fwd_ff <= 2'h0;
      ack_ff <= 2'h0;
      en_ff <= 2'h0;
      crc_ff <= 2'h0;
      rate_ff <= {`BCB_RATE_RST, `BCB_RATE_RST};
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        fwd_ff[i] <= txn_valid_i[i] &&
          (pass_all[i] ||
           (pass_match[i] && txn_match_i[i]));
        // Auto-ack covers writes only; reads wait for the remote
        ack_ff[i] <= txn_valid_i[i] &&
          ((txn_write_i && auto_ack[i]) ||
           remote_ack_i[i]);
        en_ff[i] <= force_on[i] ||
          pass_all[i] ||
          pass_match[i];
        crc_ff[i] <= check_gen[i];
      end
      rate_ff <= {cfg_ff[1][`BCB_CFG_RATE_HI:`BCB_CFG_RATE_LO],
                  cfg_ff[0][`BCB_CFG_RATE_HI:`BCB_CFG_RATE_LO]};
    end
  end

  // Bit-rate enables, one divider per port
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : rate_gen
      bcb_rate_gen u_rate (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .rate_sel_i(rate_ff[3*g+2:3*g]),
        .tick_o(tick[g])
      );
    end
  endgenerate

  assign reg_rdata_o = rdata_ff;
  assign fwd_o = fwd_ff;
  assign ack_o = ack_ff;
  assign return_link_en_o = en_ff;
  assign return_link_check_gen_en_o = crc_ff;
  assign return_link_rate_sel_o = rate_ff;
  assign return_link_tick_o = tick;
endmodule

//--- tb/bcb_checker_properties.sv
// Port-level assertions for the return channel config bank
`timescale 1ns/1ps
module bcb_checker (
  input wire clk_i,
  input wire resetn_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire [1:0] txn_valid_i,
  input wire [1:0] remote_ack_i,
  input wire [1:0] fwd_o,
  input wire [1:0] ack_o,
  input wire [5:0] return_link_rate_sel_o,
  input wire [1:0] return_link_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire [2:0] r0 = return_link_rate_sel_o[2:0];
  wire t0 = return_link_tick_o[0];
  a_fwd_cause: assert property (
    fwd_o[0] |-> $past(txn_valid_i[0]))
    else $error("forward without transaction");
  a_fwd_pulse: assert property (
    fwd_o[0] && !txn_valid_i[0] |=> !fwd_o[0])
    else $error("forward pulse too long");
  a_ack_remote: assert property (
    txn_valid_i[0] && remote_ack_i[0] |=> ack_o[0])
    else $error("remote ack lost");
  a_ack_cause: assert property (
    ack_o[0] |-> $past(txn_valid_i[0]))
    else $error("ack without transaction");
  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  a_unmapped_zero: assert property (
    reg_rd_i && reg_addr_i == 8'h99 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rate_fast: assert property (
    (r0 == 3'h7)[*4] |-> t0)
    else $error("fast rate missed tick");
  a_rate_reserved: assert property (
    (r0 == 3'h1)[*3] |-> !t0)
    else $error("tick on reserved code");
  a_rate_slow: assert property (
    t0 && r0 == 3'h0 |=> (!t0 || r0 != 3'h0)[*8])
    else $error("slow rate ticks too often");
  a_rate_ten: assert property (
    t0 && r0 == 3'h2 |=> (!t0 || r0 != 3'h2)[*4])
    else $error("ten rate ticks too often");
  c_fwd: cover property (fwd_o[0]);
  c_auto_ack: cover property (ack_o[0] && !$past(remote_ack_i[0]));
  c_mid_rate: cover property (t0 && r0 == 3'h5);
endmodule
bind bcb_config_bank bcb_checker i_bcb_checker (.clk_i, .resetn_i,
  .reg_rd_i, .reg_addr_i, .reg_rdata_o, .txn_valid_i, .remote_ack_i,
  .fwd_o, .ack_o, .return_link_rate_sel_o, .return_link_tick_o);

//--- tb/bcb_remote_model.sv
// Remote serializer acknowledge model
`timescale 1ns/1ps
module bcb_remote_model (
  input wire clk_i,
  input wire [1:0] txn_valid_i,
  input wire [1:0] nack_i,
  output wire [1:0] remote_ack_o
);
  reg [1:0] idle_ff = 2'h0;
  always @(posedge clk_i) begin
    idle_ff <= ~idle_ff;
  end
  // Ack has no meaning outside a transaction, so it toggles there
  assign remote_ack_o = (txn_valid_i & ~nack_i) | (~txn_valid_i & idle_ff);
endmodule

//--- tb/tb.sv
// Self-checking bench for the return channel config bank
`timescale 1ns/1ps
module tb;
  reg clk_i = 0, resetn_i = 0, reg_wr = 0, reg_rd = 0, reg_rem = 0;
  reg pin = 0, tw = 0;
  reg [1:0] tv = 2'h0, tm = 2'h0, nack = 2'h0;
  reg [7:0] addr = 8'h00, wdata = 8'h00;
  reg [2:0] strap = 3'h5;
  reg [1:0] bist = 2'h0;
  wire [7:0] rdata;
  wire [1:0] fwd, ack, en, crc, tick, rack;
  wire [5:0] rate;
  integer miscompares = 0, comparisons = 0;
  bcb_config_bank i_bcb_config_bank (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_remote_i(reg_rem),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .strap_rate_i(strap), .powerdown_release_pin_i(pin),
    .txn_valid_i(tv), .txn_match_i(tm), .txn_write_i(tw),
    .remote_ack_i(rack), .bist_err_i(bist), .fwd_o(fwd), .ack_o(ack),
    .return_link_en_o(en), .return_link_check_gen_en_o(crc),
    .return_link_rate_sel_o(rate), .return_link_tick_o(tick));
  bcb_remote_model i_bcb_remote_model (.clk_i(clk_i),
    .txn_valid_i(tv), .nack_i(nack), .remote_ack_o(rack));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task chk(input [7:0] e, input [7:0] s, input string n);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input r);
    begin
      @(posedge clk_i);
      reg_wr <= 1;
      addr <= a;
      wdata <= d;
      reg_rem <= r;
      @(posedge clk_i);
      reg_wr <= 0;
      reg_rem <= 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input string n);
    begin
      @(posedge clk_i);
      reg_rd <= 1;
      addr <= a;
      @(posedge clk_i);
      reg_rd <= 0;
      #1;
      chk(e, rdata, n);
    end
  endtask
  task txn(input p, input m, input w, input k, input [1:0] e,
    input string n);
    begin
      @(posedge clk_i);
      tv <= 2'b01 << p;
      tm <= {m, m};
      tw <= w;
      nack <= {k, k};
      @(posedge clk_i);
      tv <= 2'b00;
      #1;
      chk(e, {fwd[p], ack[p]}, n);
    end
  endtask
  task rate_one(input [2:0] c, input integer e);
    integer n;
    begin
      n = 0;
      wr(8'h58, {5'h03, c}, 0);
      cyc(3);
      repeat (40) begin
        cyc(1);
        n = n + tick[0];
      end
      comparisons = comparisons + 1;
      if ((n >= e - 1 && n <= e + 1) !== 1'b1) begin
        miscompares = miscompares + 1;
        $display("BAD ticks exp %0d got %0d", e, n);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task t_reset_values;
    begin
      chk(2'b11, en, "en");
      chk(2'b11, crc, "crc");
      rd(8'h57, 8'h00, "tally");
      rd(8'h58, 8'h1e, "cfg");
    end
  endtask
  task t_strap_load;
    begin
      @(posedge clk_i);
      pin <= 1;
      cyc(8);
      chk(8'h2d, rate, "strap");
    end
  endtask
  task t_force_on;
    begin
      wr(8'h58, 8'h2d, 1);
      wr(8'h58, 8'h00, 1);
      cyc(2);
      chk(1, en[0], "en");
      chk(0, crc[0], "crc");
      rd(8'h58, 8'h10, "cfg");
      wr(8'h58, 8'h00, 0);
      cyc(2);
      chk(0, en[0], "en");
      wr(8'h58, 8'h40, 0);
      cyc(2);
      chk(1, en[0], "en");
    end
  endtask
  task t_pass_through;
    begin
      txn(0, 0, 0, 0, 2'b01, "nomatch");
      txn(0, 1, 0, 0, 2'b11, "match");
      wr(8'h58, 8'h80, 0);
      txn(0, 0, 0, 1, 2'b10, "all");
      wr(8'h58, 8'h20, 0);
      txn(0, 1, 1, 1, 2'b01, "autoack");
      txn(0, 1, 0, 1, 2'b00, "read");
    end
  endtask
  task t_port_copies;
    begin
      wr(8'h4c, 8'h02, 0);
      wr(8'h58, 8'h47, 0);
      cyc(2);
      chk(8'h38, rate, "rate");
      chk(2'b10, en, "en");
      txn(1, 1, 0, 0, 2'b11, "port1");
      wr(8'h4c, 8'h10, 0);
      rd(8'h4c, 8'h10, "psel");
      rd(8'h58, 8'h47, "cfg1");
      chk(1, tick[1], "tick1");
      wr(8'h4c, 8'h01, 0);
    end
  endtask
  task t_rates;
    begin
      rate_one(3'h0, 2);
      rate_one(3'h2, 8);
      rate_one(3'h5, 20);
      rate_one(3'h6, 40);
      rate_one(3'h7, 40);
      rate_one(3'h1, 0);
    end
  endtask
  task t_tally;
    begin
      @(posedge clk_i);
      bist <= 2'b01;
      repeat (2) @(posedge clk_i);
      bist <= 2'b10;
      @(posedge clk_i);
      bist <= 2'b00;
      wr(8'h57, 8'hff, 0);
      rd(8'h57, 8'h02, "tally0");
      wr(8'h4c, 8'h10, 0);
      rd(8'h57, 8'h01, "tally1");
      rd(8'h99, 8'h00, "unmapped");
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1;
    cyc(1);
    t_reset_values;
    t_strap_load;
    t_force_on;
    t_pass_through;
    t_port_copies;
    t_rates;
    t_tally;
    stop_test;
  end
endmodule
